// >>> shared/daf_pkg.sv
// ============================================================
// Constants and carriers for the diagnostic flag and alert block.
// ============================================================
package daf_pkg;

    // Register indices on the internal register port.
    localparam logic [7:0] DAF_ADDR_ENERGY = 8'h09; // Energy accumulator.
    localparam logic [7:0] DAF_ADDR_CHARGE = 8'h0a; // Charge accumulator.
    localparam logic [7:0] DAF_ADDR_DIAG = 8'h0b; // Diagnostic register.

    // Field positions inside the diagnostic register.
    localparam int DAF_BIT_LATCH = 15; // Latched or transparent mode.
    localparam int DAF_BIT_RDY_EN = 14; // Conversion done drives alert.
    localparam int DAF_BIT_AVG_SEL = 13; // Compare averaged results.
    localparam int DAF_BIT_POL = 12; // Alert polarity.
    localparam int DAF_BIT_ENERGY_OF = 11; // Energy accumulator overflow.
    localparam int DAF_BIT_CHARGE_OF = 10; // Charge accumulator overflow.
    localparam int DAF_BIT_ARITH_OF = 9; // Arithmetic overflow.
    localparam int DAF_BIT_RSVD = 8; // Reserved, reads zero.
    localparam int DAF_BIT_LIM_MSB = 7; // Top of the limit flag field.
    localparam int DAF_BIT_LIM_LSB = 2; // Bottom of the limit flag field.
    localparam int DAF_BIT_CONV = 1; // Conversion done.
    localparam int DAF_BIT_MEM = 0; // Trim memory health.

    // Value of the diagnostic register after reset.
    localparam logic [15:0] DAF_DIAG_RESET = 16'h0001;
    localparam logic [3:0] DAF_CTRL_RESET = 4'h0;

    // One bit per limit comparison, ordered as in the register.
    typedef struct packed {
        logic temp_over; // Die temperature above its limit.
        logic shunt_over; // Shunt voltage above its limit.
        logic shunt_under; // Shunt voltage below its limit.
        logic bus_over; // Bus voltage above its limit.
        logic bus_under; // Bus voltage below its limit.
        logic power_over; // Power above its limit.
    } daf_lim_s;

    // Control bits that software writes.
    typedef struct packed {
        logic alert_latch_mode; // One holds flags until a read.
        logic ready_on_alert_enable; // One routes done to alert.
        logic averaged_compare_select; // One compares averaged values.
        logic alert_polarity_select; // One makes alert active high.
    } daf_ctrl_s;

endpackage

// >>> rtl/daf_diag_alert.sv
`timescale 1ns/1ns
// What this block does
// - Transparent mode: flags and alert follow faults.
// - Latched mode: hold alert until register read.
// - Ready-on-alert routes conversion done to alert.
// - Compare select picks raw or averaged results.
// - Polarity bit picks active-low or active-high alert.
// - Energy accumulator overflow sets its flag.
// - Reading energy accumulator clears its flag.
// - Charge accumulator overflow sets its flag.
// - Reading charge accumulator clears its flag.
// - Internal calculation overflow sets arithmetic flag.
// - New conversion or accumulator clear resets it.
// - Bit 8 always reads zero.
// - Temperature above limit sets its flag.
// - Shunt above over-limit sets its flag.
// - Shunt below under-limit sets its flag.
// - Bus above over-limit sets its flag.
// - Bus below under-limit sets its flag.
// - Power above limit sets its flag.
// - Latched mode: diagnostic read clears limit flags.
// - Reset loads diagnostic register with 0001h.
// - Done sets flag; start clears; latched: read clears.
// - Trim checksum error drives memory health low.
module daf_diag_alert
    import daf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire daf_lim_s lim_raw,
    input wire daf_lim_s lim_avg,
    input wire logic conv_done,
    input wire logic conv_start,
    input wire logic accumulator_clear_cmd,
    input wire logic energy_ovf_evt,
    input wire logic charge_ovf_evt,
    input wire logic arith_ovf_evt,
    input wire logic trim_crc_err,
    input wire logic alert_in,
    output logic alert_out,
    output logic alert_oe_n
);

    // ============================================================
    // Decode of the register port
    // ============================================================
    daf_ctrl_s ctrl; // Software controlled mode bits.
    daf_lim_s lim_flags; // Limit violation flags.
    daf_lim_s lim_sel; // Fault levels after compare select.
    daf_lim_s next_lim_flags; // Next limit flag value.
    logic energy_overflow_flag; // Sticky energy overflow.
    logic charge_overflow_flag; // Sticky charge overflow.
    logic arith_overflow_flag; // Sticky arithmetic overflow.
    logic conversion_done_flag; // Conversion completed.
    logic trim_memory_health; // One while trim memory is good.
    logic diag_rd; // Read of the diagnostic register.
    logic diag_wr; // Write of the diagnostic register.
    logic energy_rd; // Read of the energy accumulator.
    logic charge_rd; // Read of the charge accumulator.
    logic alert_active; // Alert condition before polarity.
    logic [15:0] diag_value; // Assembled register image.

    // Address matching shared by reads and writes.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    assign diag_rd = reg_rd && hit(reg_addr, DAF_ADDR_DIAG);
    assign diag_wr = reg_wr && hit(reg_addr, DAF_ADDR_DIAG);
    assign energy_rd = reg_rd && hit(reg_addr, DAF_ADDR_ENERGY);
    assign charge_rd = reg_rd && hit(reg_addr, DAF_ADDR_CHARGE);

    // ============================================================
    // Control bits
    // ============================================================
    // Only the four mode bits take written data; flags are owned
    // by hardware so a write cannot fake or lose an event.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= DAF_CTRL_RESET;
        end else if (diag_wr) begin
            ctrl <= reg_wdata[DAF_BIT_LATCH:DAF_BIT_POL];
        end
    end

    // ============================================================
    // Limit flags
    // ============================================================
    // The compare select chooses which result stream feeds the
    // flags; averaged results arrive later, delaying the alert.
    assign lim_sel = ctrl.averaged_compare_select ? lim_avg : lim_raw;

    // Transparent mode mirrors the fault level. Latched mode keeps
    // each flag until a read, and a fault seen during that read
    // still sets the flag so the event is not lost.
    always_comb begin
        if (!ctrl.alert_latch_mode) begin
            next_lim_flags = lim_sel;
        end else if (diag_rd) begin
            next_lim_flags = lim_sel;
        end else begin
            next_lim_flags = lim_flags | lim_sel;
        end
    end

    // Each bit is set by its own comparator level.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lim_flags <= '0;
        end else begin
            lim_flags <= next_lim_flags;
        end
    end

    // ============================================================
    // Conversion done flag
    // ============================================================
    // A new triggered conversion always clears the flag; a read
    // clears it only in latched mode. Completion wins over both.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            conversion_done_flag <= 1'b0;
        end else if (conv_done) begin
            conversion_done_flag <= 1'b1;
        end else if (conv_start) begin
            conversion_done_flag <= 1'b0;
        end else if (diag_rd && ctrl.alert_latch_mode) begin
            conversion_done_flag <= 1'b0;
        end
    end

    // ============================================================
    // Overflow flags
    // ============================================================
    // Energy overflow is cleared by reading the energy accumulator.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            energy_overflow_flag <= 1'b0;
        end else if (energy_ovf_evt) begin
            energy_overflow_flag <= 1'b1;
        end else if (energy_rd) begin
            energy_overflow_flag <= 1'b0;
        end
    end

    // Charge overflow is cleared by reading the charge accumulator.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            charge_overflow_flag <= 1'b0;
        end else if (charge_ovf_evt) begin
            charge_overflow_flag <= 1'b1;
        end else if (charge_rd) begin
            charge_overflow_flag <= 1'b0;
        end
    end

    // Arithmetic overflow marks current and power as suspect until
    // software restarts a conversion or clears the accumulators.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            arith_overflow_flag <= 1'b0;
        end else if (arith_ovf_evt) begin
            arith_overflow_flag <= 1'b1;
        end else if (conv_start || accumulator_clear_cmd) begin
            arith_overflow_flag <= 1'b0;
        end
    end

    // ============================================================
    // Trim memory health
    // ============================================================
    // Resets to good; a checksum error is sticky until reset since
    // the trim values stay untrusted once a mismatch was seen.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            trim_memory_health <= DAF_DIAG_RESET[DAF_BIT_MEM];
        end else if (trim_crc_err) begin
            trim_memory_health <= 1'b0;
        end
    end

    // ============================================================
    // Register read
    // ============================================================
    // The image is assembled from the live flags; bit 8 is tied.
    always_comb begin
        diag_value = '0;
        diag_value[DAF_BIT_LATCH:DAF_BIT_POL] = ctrl;
        diag_value[DAF_BIT_ENERGY_OF] = energy_overflow_flag;
        diag_value[DAF_BIT_CHARGE_OF] = charge_overflow_flag;
        diag_value[DAF_BIT_ARITH_OF] = arith_overflow_flag;
        diag_value[DAF_BIT_RSVD] = 1'b0;
        diag_value[DAF_BIT_LIM_MSB:DAF_BIT_LIM_LSB] = lim_flags;
        diag_value[DAF_BIT_CONV] = conversion_done_flag;
        diag_value[DAF_BIT_MEM] = trim_memory_health;
    end

    // Diagnostic read data is captured before its clear-on-read takes effect,
    // so software sees the limit and done events that it is clearing.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= diag_rd;
            reg_rdata <= diag_rd ? diag_value : '0;
        end
    end

    // ============================================================
    // Alert pin
    // ============================================================
    // Overflow flags are deliberately kept off the alert.
    assign alert_active = (|lim_flags) ||
        (ctrl.ready_on_alert_enable && conversion_done_flag);

    // Open drain: the pin is only ever pulled low. Active-low alert
    // pulls while active; active-high pulls while idle.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_oe_n <= 1'b1;
        end else begin
            alert_oe_n <= ~(alert_active ^ ctrl.alert_polarity_select);
        end
    end
    assign alert_out = 1'b0;

    // ============================================================
    // Checks
    // ============================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_transparent_follow: assert property (
        !ctrl.alert_latch_mode |=> lim_flags == $past(lim_sel))
        else $error("transparent flags do not follow faults");

    a_latch_hold: assert property (
        ctrl.alert_latch_mode && !diag_rd |=>
        (lim_flags & $past(lim_flags)) == $past(lim_flags))
        else $error("latched flag dropped without a read");

    a_read_clear: assert property (
        ctrl.alert_latch_mode && diag_rd && lim_sel == '0 |=>
        lim_flags == '0)
        else $error("latched read did not clear limit flags");

    a_ready_alert: assert property (
        ctrl.ready_on_alert_enable && conversion_done_flag &&
        !ctrl.alert_polarity_select |=> alert_oe_n == 1'b0)
        else $error("conversion done did not reach alert");

    a_energy_clear: assert property (
        energy_rd && !energy_ovf_evt |=> !energy_overflow_flag)
        else $error("energy read did not clear overflow");

    a_charge_set: assert property (
        charge_ovf_evt |=> charge_overflow_flag ##0
        reg_rdata[DAF_BIT_RSVD] == 1'b0)
        else $error("charge overflow not set");

    a_arith_sticky: assert property (
        arith_overflow_flag && !conv_start && !accumulator_clear_cmd
        |=> arith_overflow_flag)
        else $error("arithmetic overflow cleared early");

    a_arith_clear: assert property (
        (conv_start || accumulator_clear_cmd) && !arith_ovf_evt
        |=> !arith_overflow_flag)
        else $error("arithmetic overflow not cleared");

    a_reserved_zero: assert property (
        reg_rvalid |-> reg_rdata[DAF_BIT_RSVD] == 1'b0)
        else $error("reserved bit read as one");

    a_conv_set: assert property (
        conv_done |=> conversion_done_flag [*1] ##1
        (conversion_done_flag || $past(conv_start) || $past(diag_rd)))
        else $error("conversion done flag not set");

    a_polarity_idle: assert property (
        !alert_active && ctrl.alert_polarity_select |=> !alert_oe_n)
        else $error("active-high alert not pulled low at idle");

endmodule

// >>> bench/daf_alert_host.sv
`timescale 1ns/1ns
// ============================================================
// Host-side view of the open-drain alert line.
// ============================================================
// The board pull-up holds the line high; only the device pulls it low.
// Nothing else drives it, so a released pin never shows a stale level.
module daf_alert_host
    import daf_pkg::*;
(
    input wire logic alert_out,
    input wire logic alert_oe_n,
    output logic alert_pin
);
    // Resolved level that the host controller samples.
    assign alert_pin = alert_oe_n ? 1'b1 : alert_out;
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ns
// One comparison: counts it and reports a mismatch at once.
`define check_eq(name, exp, got) begin n_tests++; \
    if ((got) !== (exp)) begin bad_count++; \
    $display("Error %s expected %h seen %h", name, exp, got); end end
module tb_top
    import daf_pkg::*;
;
    // ============================================================
    // Stimulus, design, host and counters.
    // ============================================================
    logic core_clk, rst_n, reg_wr, reg_rd, reg_rvalid, conv_done, conv_start;
    logic accumulator_clear_cmd, energy_ovf_evt, charge_ovf_evt;
    logic arith_ovf_evt, trim_crc_err, alert_pin, alert_out, alert_oe_n;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    daf_lim_s lim_raw, lim_avg;
    int bad_count = 0; // Mismatches seen.
    int n_tests = 0; // Comparisons made.
    int seed = 72; // Fixed seed so every run repeats.
    logic [31:0] r, a, b, c; // Random words for one cycle.
    // Behavioural model state, one variable per flag field and one for the four mode bits.
    logic [3:0] m_ctrl;
    logic [5:0] m_lim;
    logic m_conv, m_eof, m_cof, m_aof, m_mem, m_rv, m_oe, rd_diag;
    logic [15:0] m_rd;

    daf_diag_alert i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .lim_raw(lim_raw), .lim_avg(lim_avg),
        .conv_done(conv_done), .conv_start(conv_start),
        .accumulator_clear_cmd(accumulator_clear_cmd),
        .energy_ovf_evt(energy_ovf_evt), .charge_ovf_evt(charge_ovf_evt),
        .arith_ovf_evt(arith_ovf_evt), .trim_crc_err(trim_crc_err),
        .alert_in(alert_pin), .alert_out(alert_out),
        .alert_oe_n(alert_oe_n));

    daf_alert_host i_host (.alert_out(alert_out), .alert_oe_n(alert_oe_n),
        .alert_pin(alert_pin));

    // The 100 MHz core clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ============================================================
    // Reference model of the register image and the alert pin.
    // ============================================================
    // Image as the host reads it; bit 8 is always zero.
    function automatic logic [15:0] image();
        return {m_ctrl, m_eof, m_cof, m_aof, 1'b0, m_lim, m_conv, m_mem};
    endfunction

    // Old state feeds the alert first, then the fields advance.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            m_ctrl = 4'h0; m_lim = 6'h00; m_conv = 1'b0; m_eof = 1'b0;
            m_cof = 1'b0; m_aof = 1'b0; m_mem = 1'b1; m_rv = 1'b0;
            m_rd = 16'h0000; m_oe = 1'b1;
        end else begin
            rd_diag = reg_rd && reg_addr == DAF_ADDR_DIAG;
            m_oe = ~((|m_lim | (m_ctrl[2] & m_conv)) ^ m_ctrl[0]);
            m_rv = rd_diag;
            m_rd = rd_diag ? image() : 16'h0000;
            if (!m_ctrl[3] || rd_diag) begin
                m_lim = m_ctrl[1] ? lim_avg : lim_raw;
            end else begin
                m_lim = m_lim | (m_ctrl[1] ? lim_avg : lim_raw);
            end
            m_conv = conv_done | (m_conv & !conv_start
                & !(rd_diag & m_ctrl[3]));
            m_eof = energy_ovf_evt
                | (m_eof & !(reg_rd && reg_addr == DAF_ADDR_ENERGY));
            m_cof = charge_ovf_evt
                | (m_cof & !(reg_rd && reg_addr == DAF_ADDR_CHARGE));
            m_aof = arith_ovf_evt
                | (m_aof & !conv_start & !accumulator_clear_cmd);
            m_mem = m_mem & !trim_crc_err;
            if (reg_wr && reg_addr == DAF_ADDR_DIAG) begin
                m_ctrl = reg_wdata[15:12];
            end
        end
    end

    // Results are settled by the falling edge, so compare there.
    always @(negedge core_clk) begin
        `check_eq("rvalid", m_rv, reg_rvalid)
        if (m_rv) `check_eq("rdata", m_rd, reg_rdata)
        `check_eq("alert_oe_n", m_oe, alert_oe_n)
        `check_eq("alert_pin", m_oe, alert_pin)
    end

    // ============================================================
    // Verdict, watchdog and main sequence.
    // ============================================================
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // The run needs about 3000 cycles; twice that means a hang.
    initial begin
        #62000;
        bad_count++;
        report_and_stop();
    end

    // Random traffic; faults are rare per bit so transparent and latched
    // modes give visibly different images.
    initial begin
        {reg_wr, reg_rd, conv_done, conv_start, accumulator_clear_cmd} = 0;
        {energy_ovf_evt, charge_ovf_evt, arith_ovf_evt, trim_crc_err} = 0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        lim_raw = '0;
        lim_avg = '0;
        rst_n = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        for (int cyc = 0; cyc < 3000; cyc++) begin
            r = $random(seed);
            a = $random(seed);
            b = $random(seed);
            c = $random(seed);
            // A second reset in mid-run, with every request held off.
            rst_n = !(cyc >= 1500 && cyc < 1503);
            if (!rst_n) begin
                r = '1;
            end
            reg_rd = r[1:0] == 2'h0;
            reg_addr = 8'h09 + 8'(r[3:2]); // Includes unmapped 0x0c.
            reg_wr = r[7:4] == 4'h0;
            reg_wdata = a[31:16];
            lim_raw = daf_lim_s'(a[5:0] & b[5:0] & c[5:0]);
            lim_avg = daf_lim_s'(a[11:6] & b[11:6] & c[11:6]);
            conv_done = r[10:8] == 3'h0;
            conv_start = r[13:11] == 3'h0;
            accumulator_clear_cmd = r[16:14] == 3'h0;
            energy_ovf_evt = r[19:17] == 3'h0;
            charge_ovf_evt = r[22:20] == 3'h0;
            arith_ovf_evt = r[25:23] == 3'h0;
            trim_crc_err = cyc == 2500;
            @(negedge core_clk);
        end
        {reg_wr, reg_rd, trim_crc_err} = 0;
        repeat (3) @(negedge core_clk);
        report_and_stop();
    end
endmodule
